// [dcs_clock_switch.sv]
// Dynamic clock switch: command decode, source control, AXI4-Lite regs
// How it works
// - At reset the select register loads from the low fuse byte; writable later.
// - Fuses map to source and startup fields; clock-output fuse enters inverted.
// - Enable turns on the selected source with the startup time chosen.
// - Enable also starts the readiness count for that source.
// - Disable turns off only the selected source, never the running system source.
// - Each source keeps its own enable, so several run together.
// - Availability request counts source ticks to the startup limit, then flags ready.
// - Ready clears when a count starts and then holds until the next.
// - Recover writes the running system source code into the source field only.
// - System clock selects among RC, watchdog osc, ext clock, LF osc, crystal.
// - Each command follows a change-enable-only write; codes 1 to 6.
// - Source code sits in the low nibble of the select register.
// - One software-enabled external source at a time; ext and LF enables shared with the timer, which can lend both at once.
// - Auto-reload overrides watchdog enable; reset action only, no interrupt.
// - Watchdog prescale field sets the timeout in both modes.
// - Auto-reload clears only by reset; watchdog reset flag records that cause.
// - Monitoring detects loss only at four or more ticks per watchdog tick.
// - Commands change only via the two-step write; one executes at a time.
`default_nettype none
module dcs_clock_switch
  import dcs_pkg::*;
#(
  parameter int CNT_W   = 16,
  parameter int LIMIT_0 = 1024,
  parameter int LIMIT_1 = 1024,
  parameter int LIMIT_2 = 16384,
  parameter int LIMIT_3 = 32768
) (
  input  wire logic          CLK,            // System clock, 10 MHz
  input  wire logic          RESET,          // Synchronous reset, high
  input  wire logic [7:0]    FUSE_LOW,       // Low configuration fuse byte
  input  wire logic          WDT_CAUSE,      // Reset was raised by watchdog
  input  wire logic [4:0]    SRC_TICK,       // Per-source tick pulses
  input  wire logic          ATMR_EXT_REQ,   // Timer wants the ext clock
  input  wire logic          ATMR_LF_REQ,    // Timer wants the LF osc
  output var  logic [4:0]    SRC_ENABLE,     // Per-source oscillator enable
  output var  logic [2:0]    SYS_SRC,        // Index driving system clock
  output var  logic          CLK_OUT_EN,     // Clock output pin enable
  output var  logic          CLK_READY,      // Readiness flag
  output var  logic [3:0]    WDT_PRESCALE,   // Watchdog timeout select
  output var  logic          WDT_RST_EN,     // Watchdog reset action on
  output var  logic          WDT_IRQ_EN,     // Watchdog interrupt on
  output var  logic          WDT_RELOAD,     // Hardware reload pulse
  input  wire logic [7:0]    S_AXI_AWADDR,   // Write address
  input  wire logic          S_AXI_AWVALID,  // Write address valid
  output var  logic          S_AXI_AWREADY,  // Write address ready
  input  wire logic [31:0]   S_AXI_WDATA,    // Write data
  input  wire logic [3:0]    S_AXI_WSTRB,    // Write strobes
  input  wire logic          S_AXI_WVALID,   // Write data valid
  output var  logic          S_AXI_WREADY,   // Write data ready
  output var  logic [1:0]    S_AXI_BRESP,    // Write response
  output var  logic          S_AXI_BVALID,   // Write response valid
  input  wire logic          S_AXI_BREADY,   // Write response ready
  input  wire logic [7:0]    S_AXI_ARADDR,   // Read address
  input  wire logic          S_AXI_ARVALID,  // Read address valid
  output var  logic          S_AXI_ARREADY,  // Read address ready
  output var  logic [31:0]   S_AXI_RDATA,    // Read data
  output var  logic [1:0]    S_AXI_RRESP,    // Read response
  output var  logic          S_AXI_RVALID,   // Read data valid
  input  wire logic          S_AXI_RREADY    // Read data ready
);
  generate
    if (LIMIT_0 < 1 || LIMIT_3 >= (1 << CNT_W) || LIMIT_2 >= (1 << CNT_W)
        || LIMIT_1 < 1) begin : g_chk
      $error("dcs_clock_switch: limits do not fit CNT_W");
    end
  endgenerate

  logic [7:0]       aw_addr_r;
  logic [7:0]       w_data_r;
  logic             w_lane0_r;
  logic             aw_full_r;
  logic             w_full_r;
  logic             wr_fire;
  logic             wr_hit;
  logic [3:0]       csel_r;
  logic [1:0]       csut_r;
  logic             clock_output_bit_r;
  logic             cce_r;
  logic [2:0]       cce_cnt_r;
  logic [4:0]       src_en_r;
  logic [2:0]       sys_ix_r;
  logic [2:0]       cnt_ix_r;
  logic [3:0]       wdp_r;
  logic             wde_r;
  logic             wdie_r;
  logic             arl_r;
  logic             watchdog_reset_flag_r;
  logic [3:0]       mon_cnt_r;
  logic             cmd_wr;
  logic             cmd_go;
  logic [3:0]       cmd;
  logic [2:0]       sel_ix;
  logic             sel_ok;
  logic             sel_ext;
  logic             ext_busy;
  logic             ena_ok;
  logic             cnt_start;
  logic [CNT_W-1:0] cnt_limit;
  logic             cnt_ready;
  logic [4:0]       tmr_grant;
  logic [31:0]      rd_val;
  logic             rd_hit;

  // Write path: address and data taken in either order
  assign wr_fire = aw_full_r && w_full_r && !S_AXI_BVALID;
  assign wr_hit  = aw_addr_r[7:2] <= DCS_OFF_STAT[7:2]
                   && aw_addr_r[1:0] == 2'h0;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      w_full_r  <= 1'b0;
      w_data_r  <= 8'h00;
      w_lane0_r <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_full_r  <= 1'b1;
      w_data_r  <= S_AXI_WDATA[7:0];
      w_lane0_r <= S_AXI_WSTRB[0];
    end else if (wr_fire) begin
      w_full_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= DCS_RESP_OK;
    end else begin
      S_AXI_AWREADY <= !aw_full_r && !(S_AXI_AWVALID && S_AXI_AWREADY);
      S_AXI_WREADY  <= !w_full_r && !(S_AXI_WVALID && S_AXI_WREADY);
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_hit ? DCS_RESP_OK : DCS_RESP_ERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Command decode: only a write to the command register with lane 0
  assign cmd_wr = wr_fire && w_lane0_r && aw_addr_r == DCS_OFF_CMD;
  assign cmd_go = cmd_wr && cce_r && !w_data_r[DCS_CCE_BIT];
  assign cmd    = w_data_r[3:0];
  assign sel_ix = dcs_code2ix(csel_r & DCS_SRC_MASK);
  assign sel_ok = sel_ix != DCS_IX_NONE;
  assign sel_ext = sel_ix >= DCS_IX_EXT && sel_ok;
  // Another external source already on and not the selected one
  assign ext_busy = |(src_en_r[4:2] & ~(3'h1 << (sel_ix - DCS_IX_EXT)));
  assign ena_ok = sel_ok && !(sel_ext && ext_busy);
  assign cnt_start = cmd_go && sel_ok
                     && ((cmd == DCS_CMD_ENA && ena_ok)
                         || cmd == DCS_CMD_REQ);

  // Change enable opens a short window that a later write cannot extend
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cce_r     <= 1'b0;
      cce_cnt_r <= 3'h0;
    end else if (cmd_wr && cce_r) begin
      cce_r     <= 1'b0;
    end else if (cmd_wr && w_data_r == DCS_CCE_ONLY) begin
      cce_r     <= 1'b1;
      cce_cnt_r <= 3'(DCS_CCE_TOUT);
    end else if (cce_r) begin
      cce_cnt_r <= cce_cnt_r - 3'h1;
      if (cce_cnt_r == 3'h1) begin
        cce_r <= 1'b0;
      end
    end
  end

  // Select register: fuse image at reset, software and recover later
  always_ff @(posedge CLK) begin
    if (RESET) begin
      csel_r <= FUSE_LOW[3:0];
      csut_r <= FUSE_LOW[DCS_SUT_LSB +: 2];
      clock_output_bit_r <= !FUSE_LOW[DCS_CLOCK_OUTPUT_BIT_BIT];
    end else if (cmd_go && cmd == DCS_CMD_REC) begin
      csel_r <= dcs_ix2code(sys_ix_r);
    end else if (wr_fire && w_lane0_r && aw_addr_r == DCS_OFF_SEL) begin
      csel_r <= w_data_r[3:0];
      csut_r <= w_data_r[DCS_SUT_LSB +: 2];
      clock_output_bit_r <= w_data_r[DCS_CLOCK_OUTPUT_BIT_BIT];
    end
  end

  // Per-source enables latched independently
  always_ff @(posedge CLK) begin
    if (RESET) begin
      src_en_r <= 5'h00;
      src_en_r[dcs_code2ix(FUSE_LOW[3:0]) == DCS_IX_NONE ? DCS_IX_RC
               : dcs_code2ix(FUSE_LOW[3:0])] <= 1'b1;
    end else if (cmd_go && cmd == DCS_CMD_ENA && ena_ok) begin
      src_en_r[sel_ix] <= 1'b1;
    end else if (cmd_go && cmd == DCS_CMD_DIS && sel_ok
                 && sel_ix != sys_ix_r) begin
      src_en_r[sel_ix] <= 1'b0;
    end
  end

  // System source moves only to a source that is running
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sys_ix_r <= dcs_code2ix(FUSE_LOW[3:0]) == DCS_IX_NONE ? DCS_IX_RC
                  : dcs_code2ix(FUSE_LOW[3:0]);
    end else if (cmd_go && cmd == DCS_CMD_SW && sel_ok
                 && src_en_r[sel_ix]) begin
      sys_ix_r <= sel_ix;
    end
  end

  // Readiness count follows the source latched at its start
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cnt_ix_r <= DCS_IX_RC;
    end else if (cnt_start) begin
      cnt_ix_r <= sel_ix;
    end
  end

  always_comb begin
    case (csut_r)
      2'h0:    cnt_limit = CNT_W'(LIMIT_0);
      2'h1:    cnt_limit = CNT_W'(LIMIT_1);
      2'h2:    cnt_limit = CNT_W'(LIMIT_2);
      default: cnt_limit = CNT_W'(LIMIT_3);
    endcase
  end

  dcs_ready_cnt #(
    .CNT_W (CNT_W)
  ) u_ready (
    .clk   (CLK),
    .reset (RESET),
    .start (cnt_start),
    .limit (cnt_limit),
    .tick  (SRC_TICK[cnt_ix_r]),
    .ready (cnt_ready),
    .busy  ()
  );

  // Timer may borrow ext or LF only while no other external is set in src_en_r; it can lend both at once
  assign tmr_grant = {1'b0,
                      ATMR_LF_REQ && !src_en_r[DCS_IX_EXT]
                        && !src_en_r[DCS_IX_XTAL],
                      ATMR_EXT_REQ && !src_en_r[DCS_IX_LF]
                        && !src_en_r[DCS_IX_XTAL],
                      2'h0};

  // Watchdog control: standard fields and sticky auto-reload
  always_ff @(posedge CLK) begin
    if (RESET) begin
      wdp_r  <= 4'h0;
      wde_r  <= 1'b0;
      wdie_r <= 1'b0;
      arl_r  <= 1'b0;
    end else begin
      if (wr_fire && w_lane0_r && aw_addr_r == DCS_OFF_WDT) begin
        wdp_r  <= w_data_r[3:0];
        wde_r  <= w_data_r[DCS_WDE_BIT];
        wdie_r <= w_data_r[DCS_WDIE_BIT];
      end
      if (cmd_go && cmd == DCS_CMD_ARL) begin
        arl_r <= 1'b1;
      end
    end
  end

  // Flag tells whether the last reset came from the watchdog
  always_ff @(posedge CLK) begin
    if (RESET) begin
      watchdog_reset_flag_r <= WDT_CAUSE;
    end else if (wr_fire && w_lane0_r && aw_addr_r == DCS_OFF_CAUSE
                 && w_data_r[DCS_WATCHDOG_RESET_FLAG_BIT]) begin
      watchdog_reset_flag_r <= 1'b0;
    end
  end

  // Reload only while system ticks outrun the watchdog osc by the ratio
  always_ff @(posedge CLK) begin
    if (RESET) begin
      mon_cnt_r  <= 4'h0;
      WDT_RELOAD <= 1'b0;
    end else begin
      WDT_RELOAD <= 1'b0;
      if (SRC_TICK[DCS_IX_WDO]) begin
        mon_cnt_r  <= 4'h0;
        WDT_RELOAD <= arl_r && mon_cnt_r >= DCS_MON_RATIO;
      end else if (SRC_TICK[sys_ix_r] && mon_cnt_r != 4'hF) begin
        mon_cnt_r <= mon_cnt_r + 4'h1;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge CLK) begin
    if (RESET) begin
      SRC_ENABLE   <= 5'h00;
      SYS_SRC      <= DCS_IX_RC;
      CLK_OUT_EN   <= 1'b0;
      CLK_READY    <= 1'b0;
      WDT_PRESCALE <= 4'h0;
      WDT_RST_EN   <= 1'b0;
      WDT_IRQ_EN   <= 1'b0;
    end else begin
      SRC_ENABLE   <= src_en_r | tmr_grant;
      SYS_SRC      <= sys_ix_r;
      CLK_OUT_EN   <= clock_output_bit_r;
      CLK_READY    <= cnt_ready;
      WDT_PRESCALE <= wdp_r;
      WDT_RST_EN   <= wde_r || arl_r;
      WDT_IRQ_EN   <= wdie_r && !arl_r;
    end
  end

  // Read path: one read at a time, answer one cycle after address
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (S_AXI_ARADDR)
      DCS_OFF_CMD:   rd_val[7:0] = {cce_r, 2'h0, cnt_ready, 4'h0};
      DCS_OFF_SEL:   rd_val[7:0] = {1'b0, clock_output_bit_r, csut_r, csel_r};
      DCS_OFF_WDT:   rd_val[7:0] = {1'b0, arl_r, wdie_r, wde_r, wdp_r};
      DCS_OFF_CAUSE: rd_val[7:0] = {4'h0, watchdog_reset_flag_r, 3'h0};
      DCS_OFF_STAT:  rd_val[15:0] = {3'h0, src_en_r, 4'h0,
                                     dcs_ix2code(sys_ix_r)};
      default:       rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= DCS_RESP_OK;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_val;
        S_AXI_RRESP  <= rd_hit ? DCS_RESP_OK : DCS_RESP_ERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  chk_fuse_load: assert property ($fell(RESET) |->
    csel_r == $past(FUSE_LOW[3:0]) && clock_output_bit_r == !$past(FUSE_LOW[6]))
    else $error("select register not loaded from fuses");
  chk_enable_on: assert property (cmd_go && cmd == DCS_CMD_ENA
    && ena_ok |=> src_en_r[$past(sel_ix)] ##1 SRC_ENABLE[$past(sel_ix, 2)])
    else $error("enable command did not turn source on");
  chk_enable_count: assert property (cmd_go && cmd == DCS_CMD_ENA
    && ena_ok |-> cnt_start ##1 !cnt_ready)
    else $error("enable command did not start count");
  chk_disable_sys: assert property (cmd_go && cmd == DCS_CMD_DIS
    && sel_ix == sys_ix_r |=> src_en_r == $past(src_en_r))
    else $error("running system source was disabled");
  chk_recover_code: assert property (cmd_go && cmd == DCS_CMD_REC
    |=> csel_r == dcs_ix2code($past(sys_ix_r)) && csut_r == $past(csut_r))
    else $error("recover wrote wrong code");
  chk_no_cce_cmd: assert property (cmd_wr && !cce_r
    |=> src_en_r == $past(src_en_r) && sys_ix_r == $past(sys_ix_r))
    else $error("command acted without change enable");
  chk_cce_timeout: assert property ($rose(cce_r) && !cmd_wr
    ##1 !cmd_wr [*4] |-> !cce_r)
    else $error("change enable did not time out");
  chk_one_external: assert property ($countones(src_en_r[4:2]) <= 1)
    else $error("two external sources enabled");
  chk_arl_sticky: assert property (arl_r |=> arl_r ##1
    (WDT_RST_EN && !WDT_IRQ_EN))
    else $error("auto-reload dropped or watchdog interrupt left on");
  chk_switch_runs: assert property ($changed(sys_ix_r)
    |-> src_en_r[sys_ix_r])
    else $error("system clock moved to a stopped source");

  cov_switch: cover property (cmd_go && cmd == DCS_CMD_SW
    ##1 $changed(sys_ix_r));
  cov_ready: cover property ($rose(CLK_READY));
  cov_reload: cover property (WDT_RELOAD);
  cov_recover: cover property (cmd_go && cmd == DCS_CMD_REC);
endmodule // dcs_clock_switch
`default_nettype wire

// [dcs_pkg.sv]
// Shared constants and helpers for the dynamic clock switch block
`default_nettype none
package dcs_pkg;
  // Register byte offsets
  localparam logic [7:0] DCS_OFF_CMD   = 8'h00;
  localparam logic [7:0] DCS_OFF_SEL   = 8'h04;
  localparam logic [7:0] DCS_OFF_WDT   = 8'h08;
  localparam logic [7:0] DCS_OFF_CAUSE = 8'h0C;
  localparam logic [7:0] DCS_OFF_STAT  = 8'h10;
  // Command register layout and codes
  localparam int         DCS_CCE_BIT   = 7;
  localparam int         DCS_RDY_BIT   = 4;
  localparam logic [7:0] DCS_CCE_ONLY  = 8'h80;
  localparam logic [3:0] DCS_CMD_DIS   = 4'h1;
  localparam logic [3:0] DCS_CMD_ENA   = 4'h2;
  localparam logic [3:0] DCS_CMD_REQ   = 4'h3;
  localparam logic [3:0] DCS_CMD_SW    = 4'h4;
  localparam logic [3:0] DCS_CMD_REC   = 4'h5;
  localparam logic [3:0] DCS_CMD_ARL   = 4'h6;
  localparam int         DCS_CCE_TOUT  = 4;
  // Select register and fuse byte layout
  localparam int         DCS_SUT_LSB   = 4;
  localparam int         DCS_CLOCK_OUTPUT_BIT_BIT  = 6;
  localparam logic [3:0] DCS_SRC_MASK  = 4'hF;
  // Watchdog control and reset cause register layout
  localparam int         DCS_WDE_BIT   = 4;
  localparam int         DCS_WDIE_BIT  = 5;
  localparam int         DCS_ARL_BIT   = 6;
  localparam int         DCS_WATCHDOG_RESET_FLAG_BIT  = 3;
  // Source indices and their select codes
  localparam int         DCS_NSRC      = 5;
  localparam logic [2:0] DCS_IX_RC     = 3'h0;
  localparam logic [2:0] DCS_IX_WDO    = 3'h1;
  localparam logic [2:0] DCS_IX_EXT    = 3'h2;
  localparam logic [2:0] DCS_IX_LF     = 3'h3;
  localparam logic [2:0] DCS_IX_XTAL   = 3'h4;
  localparam logic [2:0] DCS_IX_NONE   = 3'h7;
  localparam logic [3:0] DCS_CODE_EXT  = 4'h0;
  localparam logic [3:0] DCS_CODE_RC   = 4'h2;
  localparam logic [3:0] DCS_CODE_WDO  = 4'h3;
  localparam logic [3:0] DCS_CODE_LF   = 4'h4;
  localparam logic [3:0] DCS_CODE_XTAL = 4'h8;
  // Monitor needs this many system ticks per watchdog tick
  localparam logic [3:0] DCS_MON_RATIO = 4'h4;
  localparam logic [1:0] DCS_RESP_OK   = 2'h0;
  localparam logic [1:0] DCS_RESP_ERR  = 2'h2;

  function automatic logic [2:0] dcs_code2ix(input logic [3:0] c);
    if (c == DCS_CODE_EXT) return DCS_IX_EXT;
    if (c == DCS_CODE_RC) return DCS_IX_RC;
    if (c == DCS_CODE_WDO) return DCS_IX_WDO;
    if (c == DCS_CODE_LF) return DCS_IX_LF;
    if (c[3]) return DCS_IX_XTAL;
    return DCS_IX_NONE;
  endfunction

  function automatic logic [3:0] dcs_ix2code(input logic [2:0] i);
    case (i)
      DCS_IX_RC:   return DCS_CODE_RC;
      DCS_IX_WDO:  return DCS_CODE_WDO;
      DCS_IX_EXT:  return DCS_CODE_EXT;
      DCS_IX_LF:   return DCS_CODE_LF;
      default:     return DCS_CODE_XTAL;
    endcase
  endfunction
endpackage
`default_nettype wire

// [dcs_ready_cnt.sv]
// Oscillation cycle counter that declares a source ready
`default_nettype none
module dcs_ready_cnt
  import dcs_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             clk,    // System clock
  input  wire logic             reset,  // Synchronous reset
  input  wire logic             start,  // Begin a new count
  input  wire logic [CNT_W-1:0] limit,  // Terminal tick count
  input  wire logic             tick,   // One tick of the counted source
  output var  logic             ready,  // Count reached
  output var  logic             busy    // Count running
);
  logic [CNT_W-1:0] cnt_r;

  generate
    if (CNT_W < 3 || CNT_W > 24) begin : g_chk
      $error("dcs_ready_cnt: CNT_W out of range");
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= '0;
      busy  <= 1'b0;
    end else if (start) begin
      cnt_r <= '0;
      busy  <= 1'b1;
    end else if (busy && tick) begin
      cnt_r <= cnt_r + 1'b1;
      if (cnt_r + 1'b1 == limit) begin
        busy <= 1'b0;
      end
    end
  end

  // Flag drops at start and then holds until the next start
  always_ff @(posedge clk) begin
    if (reset || start) begin
      ready <= 1'b0;
    end else if (busy && tick && cnt_r + 1'b1 == limit) begin
      ready <= 1'b1;
    end
  end

  chk_ready_holds: assert property (@(posedge clk) disable iff (reset)
    !start && $past(!start) && $past(ready) |-> ready)
    else $error("ready flag lost without a new count");
  chk_start_clears: assert property (@(posedge clk) disable iff (reset)
    start |=> !ready && busy)
    else $error("count start did not clear ready");
endmodule // dcs_ready_cnt
`default_nettype wire

// [tb_dcs_clock_switch.sv]
// Self-checking bench for the dynamic clock switch
`default_nettype none
module tb_dcs_clock_switch import dcs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK = 1'b0, RESET = 1'b1, WDT_CAUSE = 1'b0;
  logic        ATMR_EXT_REQ = 1'b0, ATMR_LF_REQ = 1'b0;
  logic [7:0]  FUSE_LOW = 8'h32, aw = 8'h00, ar = 8'h00;
  logic [4:0]  SRC_TICK = 5'h00, SRC_ENABLE;
  logic [2:0]  SYS_SRC;
  logic [3:0]  WDT_PRESCALE;
  logic        CLK_OUT_EN, CLK_READY, WDT_RST_EN, WDT_IRQ_EN, WDT_RELOAD;
  logic [31:0] wd = 32'h0, rdat;
  logic        awv = 1'b0, wv = 1'b0, arv = 1'b0, bry = 1'b1, rry = 1'b1;
  logic        awrdy, wrdy, arrdy, bv, rv;
  logic [1:0]  br, rr, wresp;
  int          failures = 0, n_checks = 0, cyc = 0, reloads = 0;

  dcs_clock_switch #(.LIMIT_0(3), .LIMIT_1(4), .LIMIT_2(5), .LIMIT_3(6))
  dcs_clock_switch_i (
    .CLK(CLK), .RESET(RESET), .FUSE_LOW(FUSE_LOW), .WDT_CAUSE(WDT_CAUSE),
    .SRC_TICK(SRC_TICK), .ATMR_EXT_REQ(ATMR_EXT_REQ),
    .ATMR_LF_REQ(ATMR_LF_REQ), .SRC_ENABLE(SRC_ENABLE), .SYS_SRC(SYS_SRC),
    .CLK_OUT_EN(CLK_OUT_EN), .CLK_READY(CLK_READY),
    .WDT_PRESCALE(WDT_PRESCALE), .WDT_RST_EN(WDT_RST_EN),
    .WDT_IRQ_EN(WDT_IRQ_EN), .WDT_RELOAD(WDT_RELOAD),
    .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bry), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rry));

  always #50 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (WDT_RELOAD) reloads <= reloads + 1;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic ck(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h, want %h", $time, g, e);
    end
  endtask

  // Bus tasks sample ready and valid at the falling edge, where they settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d, bit s = 1);
    logic ta, tw, la, lw, b;
    if (s) @(posedge CLK);
    aw <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    la = 1;
    lw = 1;
    while (la || lw) begin
      @(negedge CLK);
      ta = awv && awrdy;
      tw = wv && wrdy;
      @(posedge CLK);
      if (ta) begin awv <= 1'b0; la = 0; end
      if (tw) begin wv <= 1'b0; lw = 0; end
    end
    b = 0;
    while (!b) begin @(negedge CLK); b = bv; wresp = br; @(posedge CLK); end
  endtask

  task automatic rc(input logic [7:0] a, input logic [33:0] e);
    logic t;
    logic [33:0] q;
    @(posedge CLK);
    ar <= a;
    arv <= 1'b1;
    t = 0;
    while (!t) begin @(negedge CLK); t = arrdy; @(posedge CLK); end
    arv <= 1'b0;
    t = 0;
    while (!t) begin @(negedge CLK); t = rv; q = {rr, rdat}; @(posedge CLK); end
    ck(q, e);
  endtask

  // Second write must follow at once: change enable lapses after 4 edges
  task automatic cmd(input logic [3:0] c);
    wr(DCS_OFF_CMD, DCS_CCE_ONLY);
    wr(DCS_OFF_CMD, {4'h0, c}, 0);
  endtask

  task automatic st();
    repeat (2) @(posedge CLK);
    @(negedge CLK);
  endtask

  task automatic tk(input logic [4:0] m, input int n);
    repeat (n) begin
      @(posedge CLK);
      SRC_TICK <= m;
      @(posedge CLK);
      SRC_TICK <= 5'h00;
    end
  endtask

  task automatic s_reset();
    ck(SRC_ENABLE, 5'h01);
    ck(SYS_SRC, DCS_IX_RC);
    ck(CLK_OUT_EN, 1'b1);
    rc(DCS_OFF_SEL, 34'h72);
    rc(DCS_OFF_CAUSE, 34'h0);
    rc(8'h14, {2'h2, 32'h0});
    rc(DCS_OFF_STAT, 34'h102);
    wr(8'h14, 8'h00);
    ck(wresp, DCS_RESP_ERR);
  endtask

  task automatic s_ready();
    wr(DCS_OFF_SEL, 8'h08);
    cmd(DCS_CMD_ENA);
    st();
    ck(SRC_ENABLE, 5'h11);
    ck({CLK_OUT_EN, CLK_READY}, 2'b00);
    tk(5'h10, 2);
    st();
    ck(CLK_READY, 1'b0);
    tk(5'h10, 1);
    st();
    ck(CLK_READY, 1'b1);
    rc(DCS_OFF_CMD, 34'h10);
    wr(DCS_OFF_SEL, 8'h12);
    cmd(DCS_CMD_REQ);
    st();
    ck(CLK_READY, 1'b0);
    tk(5'h01, 4);
    st();
    ck(CLK_READY, 1'b1);
  endtask

  task automatic s_switch();
    wr(DCS_OFF_SEL, 8'h00);
    ATMR_LF_REQ <= 1'b1;
    cmd(DCS_CMD_ENA);
    st();
    ck(SRC_ENABLE, 5'h11);
    wr(DCS_OFF_SEL, 8'h38);
    cmd(DCS_CMD_SW);
    st();
    ck(SYS_SRC, DCS_IX_XTAL);
    wr(DCS_OFF_SEL, 8'h32);
    cmd(DCS_CMD_REC);
    rc(DCS_OFF_SEL, 34'h38);
    cmd(DCS_CMD_DIS);
    st();
    ck(SRC_ENABLE, 5'h11);
    wr(DCS_OFF_SEL, 8'h02);
    cmd(DCS_CMD_DIS);
    st();
    ck(SRC_ENABLE, 5'h10);
  endtask

  task automatic s_guard();
    wr(DCS_OFF_CMD, {4'h0, DCS_CMD_ENA});
    st();
    ck(SRC_ENABLE, 5'h10);
    wr(DCS_OFF_CMD, DCS_CCE_ONLY);
    repeat (6) @(posedge CLK);
    wr(DCS_OFF_CMD, {4'h0, DCS_CMD_ENA}, 0);
    st();
    ck(SRC_ENABLE, 5'h10);
    cmd(DCS_CMD_ENA);
    st();
    ck(SRC_ENABLE, 5'h11);
  endtask

  task automatic s_wdt();
    int r0;
    wr(DCS_OFF_WDT, 8'h37);
    st();
    ck({WDT_PRESCALE, WDT_RST_EN, WDT_IRQ_EN}, 6'h1F);
    cmd(DCS_CMD_ARL);
    wr(DCS_OFF_WDT, 8'h25);
    st();
    ck({WDT_PRESCALE, WDT_RST_EN, WDT_IRQ_EN}, 6'h16);
    rc(DCS_OFF_WDT, 34'h65);
    tk(5'h02, 1);
    tk(5'h10, 3);
    st();
    r0 = reloads;
    tk(5'h02, 1);
    st();
    ck(reloads - r0, 0);
    tk(5'h10, 4);
    tk(5'h02, 1);
    st();
    ck(reloads - r0, 1);
  endtask

  task automatic s_reset2();
    @(posedge CLK);
    WDT_CAUSE <= 1'b1;
    RESET <= 1'b1;
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    WDT_CAUSE <= 1'b0;
    st();
    ck(WDT_RST_EN, 1'b0);
    ck(SRC_ENABLE, 5'h09);
    rc(DCS_OFF_CAUSE, 34'h08);
    rc(DCS_OFF_WDT, 34'h0);
    wr(DCS_OFF_CAUSE, 8'h08);
    ck(wresp, DCS_RESP_OK);
    rc(DCS_OFF_CAUSE, 34'h0);
  endtask

  initial begin
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    st();
    s_reset();
    s_ready();
    s_switch();
    s_guard();
    s_wdt();
    s_reset2();
    complete_run();
  end
endmodule // tb_dcs_clock_switch
`default_nettype wire
